// File: logic/run_pause_map.svh
// Operation
// R1 - Stop-step while running halts the target and enters pause.
// R2 - On stopping, report code segment, instruction pointer and monitor group; after a single step the code keeps report_valid low.
// R3 - Stop-step while paused runs exactly one instruction, then pauses again.
// R4 - Operator must not step across a non-maskable interrupt vector fetch.
// R5 - Trace switch defaults on; clearing it freezes trace memory.
// R6 - Trace switch off disables the whole event monitor.
// R7 - Trace switch changes are accepted during run mode too.
// R8 - Three separate timer hold switches, each defaulting off.
// R9 - Pause to run, hold off: write saved values into the timer.
// R10 - Restored mode word decides whether the timer runs during run.
// R11 - Pause to run, hold on: saved values are not written back.
// R12 - Run to pause: read each timer's mode word and count into the image.
// R13 - Hold on: nothing more after saving, the timer keeps running.
// R14 - Hold off: clear bit 15 of the mode word right after pausing.
// R15 - Saved timer registers are writable in pause; they apply at run.
// R16 - Each timer is saved and restored by its own hold switch.
`ifndef RUN_PAUSE_MAP_SVH
`define RUN_PAUSE_MAP_SVH
`define NUM_TIMERS 3
`define TIMER_ENABLE_BIT 15
`define TRACE_SWITCH_RESET 1'b1
`define HOLD_SWITCH_RESET 3'h0
`define WORD_W 16
`define GROUP_W 4
`endif

// File: logic/run_pause_pkg.sv
`include "run_pause_map.svh"
package run_pause_pkg;
    typedef enum logic [2:0]
    {
        ST_PAUSE = 3'b000,
        ST_SAVE = 3'b001,
        ST_STOP = 3'b010,
        ST_LOAD = 3'b011,
        ST_RUN = 3'b100,
        ST_STEP = 3'b101
    } ctl_state_t;
    typedef struct packed
    {
        logic [`WORD_W-1:0] mode;
        logic [`WORD_W-1:0] count;
    } timer_regs_t;
    typedef struct packed
    {
        logic [`WORD_W-1:0] cs;
        logic [`WORD_W-1:0] ip;
        logic [`GROUP_W-1:0] group;
    } stop_report_t;
endpackage

// File: logic/timer_image.sv
`include "run_pause_map.svh"
module timer_image
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic save,
    input wire logic op_write,
    input wire run_pause_pkg::timer_regs_t op_data,
    input wire run_pause_pkg::timer_regs_t target_regs,
    output run_pause_pkg::timer_regs_t image_q
);
    // Capture from the target wins over an operator write in the same cycle.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            image_q <= '0;
        else if (save)
            image_q <= target_regs; // R12
        else if (op_write)
            image_q <= op_data; // R15
    end
endmodule

// File: logic/emulation_run_pause_control.sv
`include "run_pause_map.svh"
module emulation_run_pause_control
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic stop_or_step_command,
    input wire logic run_command,
    input wire logic trace_switch_write,
    input wire logic trace_switch_value,
    input wire logic hold_switch_write,
    input wire logic [`NUM_TIMERS-1:0] hold_switch_value,
    input wire logic [`NUM_TIMERS-1:0] image_write,
    input wire run_pause_pkg::timer_regs_t image_write_data,
    input wire logic [`WORD_W-1:0] target_cs,
    input wire logic [`WORD_W-1:0] target_ip,
    input wire logic [`GROUP_W-1:0] monitor_group,
    input wire logic instr_done,
    input wire run_pause_pkg::timer_regs_t [`NUM_TIMERS-1:0] target_timers,
    output logic target_run,
    output logic pause_mode,
    output logic trace_capture_switch,
    output logic event_monitor_enable,
    output logic [`NUM_TIMERS-1:0] timer_hold_switch,
    output logic [`NUM_TIMERS-1:0] timer_write,
    output run_pause_pkg::timer_regs_t [`NUM_TIMERS-1:0] timer_write_data,
    output run_pause_pkg::timer_regs_t [`NUM_TIMERS-1:0] timer_image,
    output logic report_valid,
    output run_pause_pkg::stop_report_t stop_report
);
    run_pause_pkg::ctl_state_t state_q;
    run_pause_pkg::ctl_state_t state_d;
    logic step_q;
    logic save;
    logic after_step;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            run_pause_pkg::ST_PAUSE:
                if (stop_or_step_command || run_command)
                    state_d = run_pause_pkg::ST_LOAD;
            run_pause_pkg::ST_LOAD:
                state_d = step_q ? run_pause_pkg::ST_STEP
                                 : run_pause_pkg::ST_RUN;
            run_pause_pkg::ST_RUN:
                if (stop_or_step_command)
                    state_d = run_pause_pkg::ST_SAVE; // R1
            run_pause_pkg::ST_STEP:
                if (instr_done)
                    state_d = run_pause_pkg::ST_SAVE; // R3
            run_pause_pkg::ST_SAVE:
                state_d = run_pause_pkg::ST_STOP;
            run_pause_pkg::ST_STOP:
                state_d = run_pause_pkg::ST_PAUSE;
            default:
                state_d = run_pause_pkg::ST_PAUSE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            state_q <= run_pause_pkg::ST_PAUSE;
        else
            state_q <= state_d;
    end

    // Remembers whether the current run leg is a single step.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            step_q <= 1'b0;
        else if (state_q == run_pause_pkg::ST_PAUSE)
            step_q <= stop_or_step_command && !run_command; // R3
    end

    assign target_run = (state_q == run_pause_pkg::ST_RUN)
                     || (state_q == run_pause_pkg::ST_STEP);
    assign pause_mode = (state_q == run_pause_pkg::ST_PAUSE);
    assign save = (state_q == run_pause_pkg::ST_SAVE);

    // The switch is taken in any mode so trace can be frozen while running.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            trace_capture_switch <= `TRACE_SWITCH_RESET; // R5
        else if (trace_switch_write)
            trace_capture_switch <= trace_switch_value; // R7
    end

    assign event_monitor_enable = trace_capture_switch; // R6

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            timer_hold_switch <= `HOLD_SWITCH_RESET; // R8
        else if (hold_switch_write)
            timer_hold_switch <= hold_switch_value; // R8
    end

    // A step is also a run-to-pause transition, but report_valid stays low after it.
    assign after_step = step_q;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            report_valid <= 1'b0;
            stop_report <= '0;
        end
        else
        begin
            report_valid <= save && !after_step; // R2
            if (save)
            begin
                stop_report.cs <= target_cs; // R2
                stop_report.ip <= target_ip;
                stop_report.group <= monitor_group;
            end
        end
    end

    genvar t;
    generate
        for (t = 0; t < `NUM_TIMERS; t = t + 1)
        begin : g_timer
            logic op_wr;
            assign op_wr = image_write[t] && pause_mode; // R15
            timer_image u_image
            (
                .clk(clk),
                .reset_n(reset_n),
                .save(save), // R12
                .op_write(op_wr),
                .op_data(image_write_data),
                .target_regs(target_timers[t]),
                .image_q(timer_image[t])
            );
            // Each timer follows only its own hold switch.
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    timer_write[t] <= 1'b0;
                    timer_write_data[t] <= '0;
                end
                else if (state_d == run_pause_pkg::ST_LOAD
                         && state_q == run_pause_pkg::ST_PAUSE)
                begin
                    // The restored mode word sets run-mode activity.
                    timer_write[t] <= !timer_hold_switch[t]; // R9 R11 R16
                    timer_write_data[t] <= timer_image[t]; // R10
                end
                else if (state_q == run_pause_pkg::ST_SAVE)
                begin
                    // The image only holds the captured values one cycle
                    // later, so the stop write takes them from the target.
                    timer_write[t] <= !timer_hold_switch[t]; // R13 R14 R16
                    timer_write_data[t] <= target_timers[t];
                    timer_write_data[t].mode[`TIMER_ENABLE_BIT] <= 1'b0;
                end
                else
                    timer_write[t] <= 1'b0;
            end
        end
    endgenerate

    // Write-back is ordered after capture: SAVE captures, STOP writes.
    a_stop_halts: assert property ( // R1
        @(posedge clk) disable iff (!reset_n)
        state_q == run_pause_pkg::ST_RUN && stop_or_step_command
        |=> ##[0:2] !target_run) else $error("stop did not halt");
    a_report_after: assert property ( // R2
        @(posedge clk) disable iff (!reset_n)
        $rose(report_valid) |-> $past(save)) else $error("bad report");
    a_report_data: assert property ( // R2
        @(posedge clk) disable iff (!reset_n)
        save |=> stop_report == {$past(target_cs), $past(target_ip),
        $past(monitor_group)}) else $error("report data not taken");
    a_step_returns: assert property ( // R3
        @(posedge clk) disable iff (!reset_n)
        state_q == run_pause_pkg::ST_STEP && instr_done
        |=> ##2 pause_mode) else $error("step did not pause");
    a_step_quiet: assert property ( // R3
        @(posedge clk) disable iff (!reset_n)
        state_q == run_pause_pkg::ST_STEP && instr_done
        |=> ##1 !report_valid) else $error("step raised a report");
    a_monitor_gate: assert property ( // R6
        @(posedge clk) disable iff (!reset_n)
        trace_switch_write && !trace_switch_value |=> !event_monitor_enable)
        else $error("monitor active");
    a_trace_live: assert property ( // R7
        @(posedge clk) disable iff (!reset_n)
        trace_switch_write
        |=> trace_capture_switch == $past(trace_switch_value))
        else $error("trace switch ignored");
    a_hold_take: assert property ( // R8
        @(posedge clk) disable iff (!reset_n)
        hold_switch_write
        |=> timer_hold_switch == $past(hold_switch_value))
        else $error("hold switch ignored");
    // The hold switch may be rewritten in the launch cycle itself, so the
    // checks key on the value seen at the edge that leaves pause.
    a_hold_noload: assert property ( // R11
        @(posedge clk) disable iff (!reset_n)
        state_q == run_pause_pkg::ST_PAUSE
        && state_d == run_pause_pkg::ST_LOAD && timer_hold_switch[1]
        |=> !timer_write[1]) else $error("held timer written");
    a_restore_load: assert property ( // R9
        @(posedge clk) disable iff (!reset_n)
        state_q == run_pause_pkg::ST_PAUSE
        && state_d == run_pause_pkg::ST_LOAD && !timer_hold_switch[0]
        |=> timer_write[0] && timer_write_data[0] == $past(timer_image[0]))
        else $error("timer not restored");
    a_run_resumes: assert property ( // R9
        @(posedge clk) disable iff (!reset_n)
        state_q == run_pause_pkg::ST_LOAD |=> target_run)
        else $error("target did not resume");
    a_stop_clear: assert property ( // R14
        @(posedge clk) disable iff (!reset_n)
        state_q == run_pause_pkg::ST_STOP && timer_write[0]
        |-> !timer_write_data[0].mode[`TIMER_ENABLE_BIT])
        else $error("timer not stopped");
    a_stop_count: assert property ( // R14
        @(posedge clk) disable iff (!reset_n)
        state_q == run_pause_pkg::ST_SAVE && !timer_hold_switch[2]
        |=> timer_write[2]
        && timer_write_data[2].count == $past(target_timers[2].count))
        else $error("stale count written back");
    a_held_running: assert property ( // R13
        @(posedge clk) disable iff (!reset_n)
        state_q == run_pause_pkg::ST_SAVE && timer_hold_switch[1]
        |=> !timer_write[1]) else $error("held timer stopped");
    a_save_image: assert property ( // R12
        @(posedge clk) disable iff (!reset_n)
        save |=> timer_image[1] == $past(target_timers[1]))
        else $error("image not saved");
    a_image_locked: assert property ( // R15
        @(posedge clk) disable iff (!reset_n)
        !pause_mode && !save |=> timer_image[2] == $past(timer_image[2]))
        else $error("image written outside pause");
endmodule

// File: tb/target_model.sv
module target_model
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic target_run,
    input wire logic [2:0] timer_write,
    input wire run_pause_pkg::timer_regs_t [2:0] timer_write_data,
    output run_pause_pkg::timer_regs_t [2:0] target_timers,
    output logic [15:0] target_cs,
    output logic [15:0] target_ip,
    output logic [3:0] monitor_group,
    output logic instr_done
);
    timeunit 1ns;
    timeprecision 1ns;
    parameter logic [15:0] CS = 16'h1234;
    parameter logic [3:0] GROUP = 4'h5;
    logic [1:0] phase_q;
    assign target_cs = CS;
    assign monitor_group = GROUP;
    // Each instruction takes three cycles; there is no interrupt source.
    assign instr_done = target_run && phase_q == 2'h2;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phase_q <= 2'h0;
            target_ip <= 16'h0100;
        end
        else if (target_run)
        begin
            phase_q <= instr_done ? 2'h0 : phase_q + 2'h1;
            if (instr_done)
                target_ip <= target_ip + 16'h1;
        end
    end
    // Timers start enabled so a held timer visibly runs through pause.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            target_timers <= {3{32'h8000_0000}};
        else
            for (int i = 0; i < 3; i++)
                if (timer_write[i])
                    target_timers[i] <= timer_write_data[i];
                else if (target_timers[i].mode[15])
                    target_timers[i].count <= target_timers[i].count + 16'h1;
    end
endmodule

// File: tb/emulation_run_pause_control_test.sv
module emulation_run_pause_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, reset_n = 1'b0, stop = 1'b0, run = 1'b0, tw = 1'b0;
    logic tv = 1'b1, hw = 1'b0, instr_done, target_run, pause_mode;
    logic [2:0] hv = 3'h0, iw = 3'h0, hold, timer_write;
    logic [15:0] cs, ip, t1, ip0;
    logic [3:0] grp;
    logic trace_sw, mon_en, report_valid;
    run_pause_pkg::timer_regs_t idata = '0;
    run_pause_pkg::timer_regs_t [2:0] timers, wdata, image;
    run_pause_pkg::stop_report_t report;
    int errors = 0, check_count = 0;
    always #20 clk = ~clk;
    emulation_run_pause_control uut (.clk(clk), .reset_n(reset_n),
        .stop_or_step_command(stop), .run_command(run),
        .trace_switch_write(tw), .trace_switch_value(tv),
        .hold_switch_write(hw), .hold_switch_value(hv), .image_write(iw),
        .image_write_data(idata), .target_cs(cs), .target_ip(ip),
        .monitor_group(grp), .instr_done(instr_done),
        .target_timers(timers), .target_run(target_run),
        .pause_mode(pause_mode), .trace_capture_switch(trace_sw),
        .event_monitor_enable(mon_en), .timer_hold_switch(hold),
        .timer_write(timer_write), .timer_write_data(wdata),
        .timer_image(image), .report_valid(report_valid),
        .stop_report(report));
    target_model model (.clk(clk), .reset_n(reset_n),
        .target_run(target_run), .timer_write(timer_write),
        .timer_write_data(wdata), .target_timers(timers), .target_cs(cs),
        .target_ip(ip), .monitor_group(grp), .instr_done(instr_done));
    function automatic logic [31:0] img(input int i);
        return {16'h8000 + 16'(i), 16'h0010 * 16'(i + 1)};
    endfunction
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // 0 pause, 1 timer write, 2 report, 3 target running.
    task automatic wait_on(input int w);
        for (int k = 0; k < 50; k++)
        begin
            if ((w == 0 && pause_mode === 1'b1) ||
                (w == 1 && timer_write !== 3'h0) ||
                (w == 2 && report_valid === 1'b1) ||
                (w == 3 && target_run === 1'b1))
                return;
            tick(1);
        end
        errors++;
        $display("mismatch at %0t: wait %0d timed out", $time, w);
        test_done();
    endtask
    initial
    begin
        tick(6);
        reset_n = 1'b1;
        tick(1);
        check(36'({trace_sw, mon_en, hold}), 36'h18);
        check(36'(hold), 36'h0);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk);
            iw <= 3'h1 << i;
            idata <= img(i);
        end
        @(posedge clk);
        iw <= 3'h0;
        hw <= 1'b1;
        hv <= 3'h2;
        @(posedge clk);
        hw <= 1'b0;
        run <= 1'b1;
        tick(1);
        run <= 1'b0;
        check(36'(hold), 36'h2);
        wait_on(1);
        check(36'(timer_write), 36'h5);
        check(36'(wdata[0]), 36'(img(0)));
        check(36'(wdata[2]), 36'(img(2)));
        wait_on(3);
        tick(3);
        check(36'(timers[0].count > 16'h0010), 36'h1);
        @(posedge clk);
        tw <= 1'b1;
        tv <= 1'b0;
        iw <= 3'h4;
        idata <= '0;
        tick(1);
        tw <= 1'b0;
        iw <= 3'h0;
        tick(1);
        check(36'({trace_sw, mon_en}), 36'h0);
        check(36'(image[2]), 36'(img(2)));
        check(36'(target_run), 36'h1);
        @(posedge clk);
        tw <= 1'b1;
        tv <= 1'b1;
        stop <= 1'b1;
        tick(1);
        tw <= 1'b0;
        stop <= 1'b0;
        wait_on(2);
        check(36'(report), {16'h1234, ip, 4'h5});
        check(36'(timer_write), 36'h5);
        check(36'(wdata[2].mode), 36'h0002);
        wait_on(0);
        check(36'({target_run, mon_en}), 36'h1);
        t1 = timers[1].count;
        tick(4);
        check(36'(timers[1].count), 36'(t1 + 16'h4));
        check(36'(image[0].mode), 36'h8000);
        check(36'(timers[0].count), 36'(image[0].count));
        ip0 = ip;
        @(posedge clk);
        stop <= 1'b1;
        tick(1);
        stop <= 1'b0;
        wait_on(3);
        wait_on(0);
        check(36'(ip), 36'(ip0 + 16'h1));
        test_done();
    end
endmodule
